/* File: hdl/rsm_top.sv */
// Reset source manager: source combining, cause recording and register port
`timescale 1ns/100ps
`default_nettype none
`include "rsm_regs.svh"

module rsm_top #(
  parameter int PIN_FILTER_CYCLES =
    (`RSM_PIN_FILTER_NS + `RSM_CLK_NS - 1) / `RSM_CLK_NS
) (
  // Clock and power-on reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Register port
  input  wire logic [`RSM_ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [31:0]              reg_rdata,
  // Supply fault lines, unreg, reg, analog 0, analog 1
  input  wire logic [`RSM_FAULT_W-1:0]  supply_fault_n,
  // Backup detectors, drive reg, input, unreg, reg
  input  wire logic [`RSM_FAULT_W-1:0]  backup_fault,
  // External reset pin
  input  wire logic                     external_reset_pin_n,
  // Same-clock event sources
  input  wire logic                     watchdog_timeout,
  input  wire logic                     lockup,
  input  wire logic                     core_reset_request,
  input  wire logic                     deep_sleep_entry,
  input  wire logic                     deep_sleep_pin_wake,
  input  wire logic                     backup_mode_exit,
  input  wire logic                     hard_cause_clear,
  // Reset outputs
  output var  logic                     full_reset_n,
  output var  logic                     system_reset_n,
  output var  logic                     backup_domain_reset_enable,
  // Interrupt
  output var  logic                     irq
);

  localparam logic [`RSM_PIN_CNT_W-1:0] PIN_LAST =
    `RSM_PIN_CNT_W'(PIN_FILTER_CYCLES - 1);

  // Takes the new level only once stages two and three agree
  function automatic logic [`RSM_FAULT_W-1:0] rsm_agree(
    input logic [`RSM_FAULT_W-1:0] cur,
    input logic [`RSM_FAULT_W-1:0] s2,
    input logic [`RSM_FAULT_W-1:0] s3
  );
    rsm_agree = (s2 & s3) | (cur & (s2 | s3));
  endfunction

  rsm_pkg::rsm_state_t              q;
  rsm_pkg::rsm_state_t              d;
  logic                             lock_ev;
  logic                             full_src;
  logic                             sys_src;
  logic [`RSM_CAUSE_W-1:0]          set_v;
  logic [`RSM_CAUSE_W-1:0]          clr_v;
  logic [`RSM_CAUSE_W-1:0]          iclr_v;
  logic [`RSM_FAULT_W-1:0]          pin_tmp;

  always_comb
  begin
    d = q;
    pin_tmp = '0;
    set_v = '0;
    clr_v = '0;
    iclr_v = '0;

    // Fault lines come from analog cells, hence the three stages
    d.flt_s1 = ~supply_fault_n; // [R1] [R2]
    d.flt_s2 = q.flt_s1;
    d.flt_s3 = q.flt_s2;
    d.flt = rsm_agree(q.flt, q.flt_s2, q.flt_s3);

    d.bk_s1 = backup_fault;
    d.bk_s2 = q.bk_s1;
    d.bk_s3 = q.bk_s2;
    d.bk = rsm_agree(q.bk, q.bk_s2, q.bk_s3);

    d.pin_s1 = ~external_reset_pin_n;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    pin_tmp = rsm_agree({3'h0, q.pin_sync}, {3'h0, q.pin_s2}, {3'h0, q.pin_s3});
    d.pin_sync = pin_tmp[0];

    // Glitch filter: a level must hold the full window to count
    if (q.pin_sync == q.pin_flt)
    begin
      d.pin_cnt = '0;
    end
    else if (q.pin_cnt >= PIN_LAST)
    begin
      d.pin_flt = q.pin_sync; // [R3]
      d.pin_cnt = '0;
    end
    else
    begin
      d.pin_cnt = q.pin_cnt + `RSM_PIN_CNT_W'(1);
    end

    lock_ev = lockup & ~q.ctrl[`RSM_CTRL_LOCK_DIS]; // [R5]

    // Sources that also take the debug interface down
    full_src = (|q.flt) | q.pin_flt | watchdog_timeout; // [R2] [R4] [R17]
    sys_src = full_src | lock_ev | core_reset_request; // [R5] [R6]

    // Cause set terms, applied every cycle the source is active
    set_v[`RSM_C_POR] = q.por_pend; // [R11] [R19]
    set_v[`RSM_C_UNREG] = q.flt[0];
    set_v[`RSM_C_REG] = q.flt[1];
    set_v[`RSM_C_PIN] = q.pin_flt;
    set_v[`RSM_C_WDOG] = watchdog_timeout; // [R4]
    set_v[`RSM_C_LOCK] = lock_ev;
    set_v[`RSM_C_SYSREQ] = core_reset_request;
    set_v[`RSM_C_SLEEP] = deep_sleep_entry; // [R7]
    set_v[`RSM_C_WAKE] = deep_sleep_pin_wake; // [R8]
    set_v[`RSM_C_AN0] = q.flt[2]; // [R12]
    set_v[`RSM_C_AN1] = q.flt[3];
    set_v[`RSM_C_BK_HI:`RSM_C_BK_LO] = q.bk;
    set_v[`RSM_C_BKMODE] = backup_mode_exit;

    // Two clear paths; software must use both to clear all
    if (reg_wr && (reg_addr == `RSM_OFF_CMD) && reg_wdata[`RSM_CMD_CLR])
    begin
      clr_v = clr_v | `RSM_SOFT_CLR_MASK; // [R15]
    end
    if (hard_cause_clear)
    begin
      clr_v = clr_v | ~`RSM_SOFT_CLR_MASK; // [R15] [R16]
    end

    // Set wins over clear so no event is lost
    d.cause = (q.cause & ~clr_v) | set_v; // [R14] [R19]
    d.por_pend = 1'b0;

    if (reg_wr && (reg_addr == `RSM_OFF_IRQ_CLEAR))
    begin
      iclr_v = reg_wdata[`RSM_CAUSE_W-1:0];
    end
    d.irq_st = (q.irq_st & ~iclr_v) | (set_v & ~q.cause);

    if (reg_wr && (reg_addr == `RSM_OFF_IRQ_ENABLE))
    begin
      d.irq_en = reg_wdata[`RSM_CAUSE_W-1:0];
    end

    if (reg_wr && (reg_addr == `RSM_OFF_CTRL))
    begin
      d.ctrl = reg_wdata[`RSM_CTRL_W-1:0]; // [R9] [R10] [R13]
    end

    d.irq = |(d.irq_st & d.irq_en);

    // Release sequence for the full reset
    if (full_src)
    begin
      d.st = rsm_pkg::RSM_ST_HOLD; // [R17] [R18]
    end
    else
    begin
      case (q.st)
        rsm_pkg::RSM_ST_HOLD:
        begin
          d.st = rsm_pkg::RSM_ST_REL1;
        end
        rsm_pkg::RSM_ST_REL1:
        begin
          d.st = rsm_pkg::RSM_ST_REL2;
        end
        rsm_pkg::RSM_ST_REL2:
        begin
          d.st = rsm_pkg::RSM_ST_RUN; // [R18]
        end
        rsm_pkg::RSM_ST_RUN:
        begin
          d.st = rsm_pkg::RSM_ST_RUN;
        end
        default:
        begin
          d.st = rsm_pkg::RSM_ST_HOLD;
        end
      endcase
    end
    d.full_rst_n = (d.st == rsm_pkg::RSM_ST_RUN);

    // System reset follows full reset plus lockup and request
    if (sys_src)
    begin
      d.sys_pipe = 2'h0; // [R5] [R6] [R18]
    end
    else
    begin
      d.sys_pipe = {q.sys_pipe[0], 1'b1};
    end
    d.sys_rst_n = d.sys_pipe[1] & d.full_rst_n;

    // Read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `RSM_OFF_CTRL:
        begin
          d.rdata = {{(32-`RSM_CTRL_W){1'b0}}, q.ctrl};
        end
        `RSM_OFF_CAUSE:
        begin
          d.rdata = {{(32-`RSM_CAUSE_W){1'b0}}, q.cause}; // [R9] [R13]
        end
        `RSM_OFF_IRQ_STATUS:
        begin
          d.rdata = {{(32-`RSM_CAUSE_W){1'b0}}, q.irq_st};
        end
        `RSM_OFF_IRQ_ENABLE:
        begin
          d.rdata = {{(32-`RSM_CAUSE_W){1'b0}}, q.irq_en};
        end
        default:
        begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // Power-on reset is the block's own reset; pending flag marks it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.ctrl <= `RSM_CTRL_RST; // [R10]
      q.cause <= `RSM_CAUSE_RST; // [R13]
      q.por_pend <= 1'b1;
      q.st <= rsm_pkg::RSM_ST_HOLD;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign full_reset_n = q.full_rst_n;
  assign system_reset_n = q.sys_rst_n;
  assign backup_domain_reset_enable = q.ctrl[`RSM_CTRL_BK_EN];
  assign irq = q.irq;

endmodule // rsm_top
`default_nettype wire

/* File: hdl/rsm_regs.svh */
// Register map, field positions, reset values and timing of the reset source manager
//
// How it works
// R1: Four independent supply fault detector inputs.
// R2: Low fault line acts as reset source.
// R3: Pin reset passes a glitch filter.
// R4: Watchdog expiry gives full reset, recorded.
// R5: Lockup resets system unless disable bit set.
// R6: Core reset request resets all except debug.
// R7: Deep sleep entry sets cause bit 7.
// R8: Pin wake from deep sleep sets bit 8.
// R9: Control 0x000, cause 0x004, command 0x008.
// R10: Backup domain reset enable resets to one.
// R11: Cause bits 0 to 6 as mapped.
// R12: Bits 9 to 15 analog, backup, mode.
// R13: Causes reset zero, read only, reserved zero.
// R14: Cause bits sticky until software clears.
// R15: Command clear drops lockup and request only.
// R16: Software clears command, then aux bit pulse.
// R17: Full sources reset debug; hold while active.
// R18: Assert at once, release after two stages.
// R19: Cause set every cycle source is active.
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH

`define RSM_ADDR_W         12
`define RSM_OFF_CTRL       12'h000
`define RSM_OFF_CAUSE      12'h004
`define RSM_OFF_CMD        12'h008
`define RSM_OFF_IRQ_STATUS 12'h00C
`define RSM_OFF_IRQ_ENABLE 12'h010
`define RSM_OFF_IRQ_CLEAR  12'h014

`define RSM_CTRL_W         2
`define RSM_CTRL_LOCK_DIS  0
`define RSM_CTRL_BK_EN     1
`define RSM_CTRL_RST       2'h2
`define RSM_CMD_CLR        0

`define RSM_CAUSE_W        16
`define RSM_CAUSE_RST      16'h0000
`define RSM_C_POR          0
`define RSM_C_UNREG        1
`define RSM_C_REG          2
`define RSM_C_PIN          3
`define RSM_C_WDOG         4
`define RSM_C_LOCK         5
`define RSM_C_SYSREQ       6
`define RSM_C_SLEEP        7
`define RSM_C_WAKE         8
`define RSM_C_AN0          9
`define RSM_C_AN1          10
`define RSM_C_BK_LO        11
`define RSM_C_BK_HI        14
`define RSM_C_BKMODE       15
`define RSM_SOFT_CLR_MASK  16'h0060

`define RSM_FAULT_W        4
`define RSM_PIN_CNT_W      8
`define RSM_CLK_NS         8
`define RSM_PIN_FILTER_NS  100

`endif

/* File: hdl/rsm_pkg.sv */
// Types of the reset source manager
`include "rsm_regs.svh"
package rsm_pkg;

  typedef enum logic [3:0] {
    RSM_ST_HOLD = 4'h1,
    RSM_ST_REL1 = 4'h2,
    RSM_ST_REL2 = 4'h4,
    RSM_ST_RUN  = 4'h8
  } rsm_fsm_t;

  typedef struct packed {
    logic [`RSM_CTRL_W-1:0]    ctrl;
    logic [`RSM_CAUSE_W-1:0]   cause;
    logic [`RSM_CAUSE_W-1:0]   irq_st;
    logic [`RSM_CAUSE_W-1:0]   irq_en;
    logic [31:0]               rdata;
    logic                      irq;
    logic [`RSM_FAULT_W-1:0]   flt_s1;
    logic [`RSM_FAULT_W-1:0]   flt_s2;
    logic [`RSM_FAULT_W-1:0]   flt_s3;
    logic [`RSM_FAULT_W-1:0]   flt;
    logic [`RSM_FAULT_W-1:0]   bk_s1;
    logic [`RSM_FAULT_W-1:0]   bk_s2;
    logic [`RSM_FAULT_W-1:0]   bk_s3;
    logic [`RSM_FAULT_W-1:0]   bk;
    logic                      pin_s1;
    logic                      pin_s2;
    logic                      pin_s3;
    logic                      pin_sync;
    logic                      pin_flt;
    logic [`RSM_PIN_CNT_W-1:0] pin_cnt;
    logic                      por_pend;
    rsm_fsm_t                  st;
    logic [1:0]                sys_pipe;
    logic                      full_rst_n;
    logic                      sys_rst_n;
  } rsm_state_t;

endpackage

/* File: verification/rsm_chk.sv */
// Port checker of the reset source manager
`timescale 1ns/100ps
`default_nettype none
module rsm_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_rdata,
  input wire logic        watchdog_timeout,
  input wire logic        lockup,
  input wire logic        core_reset_request,
  input wire logic        full_reset_n,
  input wire logic        system_reset_n,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_low3;
    !full_reset_n [*3];
  endsequence
  property p_wdog;
    watchdog_timeout |=> !full_reset_n && !system_reset_n;
  endproperty
  property p_sysreq;
    core_reset_request |=> !system_reset_n;
  endproperty
  property p_full_sys;
    !full_reset_n |-> !system_reset_n;
  endproperty
  property p_rdata;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  property p_hold;
    watchdog_timeout |=> s_low3;
  endproperty
  property p_rise;
    $rose(full_reset_n) |-> !$past(watchdog_timeout, 3) && !$past(watchdog_timeout, 2);
  endproperty
  property p_sys_rise;
    $rose(system_reset_n) |-> !$past(core_reset_request) && !$past(lockup);
  endproperty
  // Only software writes may drop the interrupt
  property p_irq;
    $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog gave no reset");
  a_sysreq: assert property (p_sysreq) else $error("request gave no reset");
  a_full_sys: assert property (p_full_sys) else $error("full without system");
  a_rdata: assert property (p_rdata) else $error("read data not idle");
  a_hold: assert property (p_hold) else $error("reset released early");
  a_rise: assert property (p_rise) else $error("full reset rose early");
  a_sys_rise: assert property (p_sys_rise) else $error("system rose early");
  a_irq: assert property (p_irq) else $error("irq fell alone");
endmodule // rsm_chk
`default_nettype wire

/* File: verification/test_reset_source_manager.sv */
// Self-checking bench of the reset source manager
`timescale 1ns/100ps
`default_nettype none
`include "rsm_regs.svh"
module test_reset_source_manager;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [11:0] a = 0;
  logic [31:0] wd = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic [31:0] rdat;
  logic [3:0]  sf = 4'hF;
  logic [3:0]  bf = 4'h0;
  logic        pin = 1;
  logic [5:0]  ev = 6'h00;
  logic        hcc = 0;
  logic        frn, srn, bke, irq;
  logic [15:0] ec = 16'h0001;
  logic [31:0] d;
  integer      seed = 32'hE7F8;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // Short filter keeps the pin tests brief
  rsm_top #(.PIN_FILTER_CYCLES(2)) rsm_top_inst (
    .clk, .rst_n, .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .supply_fault_n(sf), .backup_fault(bf),
    .external_reset_pin_n(pin), .watchdog_timeout(ev[0]), .lockup(ev[1]),
    .core_reset_request(ev[2]), .deep_sleep_entry(ev[3]), .deep_sleep_pin_wake(ev[4]),
    .backup_mode_exit(ev[5]), .hard_cause_clear(hcc), .full_reset_n(frn),
    .system_reset_n(srn), .backup_domain_reset_enable(bke), .irq);
  function automatic logic [15:0] ev_bit(input int k);
    logic [3:0] p [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
    return 16'h0001 << p[k];
  endfunction
  function automatic logic [15:0] flt_bit(input int k);
    logic [3:0] q [4] = '{4'h1, 4'h2, 4'h9, 4'hA};
    return 16'h0001 << ((k < 4) ? q[k] : k + 7);
  endfunction
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wreg(input logic [11:0] ad, input logic [31:0] v);
    @(posedge clk);
    a <= ad;
    wd <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [11:0] ad, input logic [31:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdat, e);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1;
    @(posedge clk);
    ev[k] <= 0;
    repeat (6) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
    forever #4 clk = ~clk;
  initial
  begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    repeat (8) @(posedge clk);
    chk("full", frn, 1);
    rreg(`RSM_OFF_CTRL, 2);
    chk("bke", bke, 1);
    rreg(`RSM_OFF_CAUSE, 1);
    rreg(`RSM_OFF_CMD, 0);
    rreg(12'hFFC, 0);
    wreg(`RSM_OFF_CAUSE, 32'hFFFF);
    rreg(`RSM_OFF_CAUSE, 1);
    wreg(`RSM_OFF_IRQ_ENABLE, 32'hFFFF);
    repeat (2) @(posedge clk);
    #1 chk("irq", irq, 1);
    for (int k = 0; k < 6; k++)
    begin
      wreg(`RSM_OFF_IRQ_CLEAR, 32'hFFFF);
      pulse(k);
      ec = ec | ev_bit(k);
      #1 chk("irq", irq, 1);
      rreg(`RSM_OFF_CAUSE, ec);
    end
    wreg(`RSM_OFF_CMD, 1);
    ec = ec & 16'hFF9F;
    rreg(`RSM_OFF_CAUSE, ec);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      if (k < 4)
        sf[k] <= 0;
      else
        bf[k - 4] <= 1;
      repeat (12) @(posedge clk);
      sf <= 4'hF;
      bf <= 4'h0;
      repeat (12) @(posedge clk);
      ec = ec | flt_bit(k);
      rreg(`RSM_OFF_CAUSE, ec);
    end
    @(posedge clk);
    hcc <= 1;
    @(posedge clk);
    hcc <= 0;
    ec = ec & 16'h0060;
    rreg(`RSM_OFF_CAUSE, ec);
    @(posedge clk);
    pin <= 0;
    @(posedge clk);
    pin <= 1;
    repeat (12) @(posedge clk);
    rreg(`RSM_OFF_CAUSE, ec);
    @(posedge clk);
    pin <= 0;
    repeat (12) @(posedge clk);
    pin <= 1;
    repeat (12) @(posedge clk);
    ec = ec | 16'h0008;
    rreg(`RSM_OFF_CAUSE, ec);
    for (int r = 0; r < 4; r++)
    begin
      d = $random(seed);
      wreg(`RSM_OFF_CTRL, d);
      rreg(`RSM_OFF_CTRL, d & 32'h3);
      chk("bke", bke, d[1]);
    end
    wreg(`RSM_OFF_CTRL, 1);
    @(posedge clk);
    ev[1] <= 1;
    @(posedge clk);
    ev[1] <= 0;
    #1 chk("srn", srn, 1);
    repeat (6) @(posedge clk);
    rreg(`RSM_OFF_CAUSE, ec);
    wreg(`RSM_OFF_IRQ_ENABLE, 0);
    pulse(0);
    #1 chk("irq", irq, 0);
    final_report;
  end
endmodule // test_reset_source_manager
bind rsm_top rsm_chk rsm_chk_inst (.clk, .rst_n, .reg_rd, .reg_wr, .reg_rdata,
  .watchdog_timeout, .lockup, .core_reset_request, .full_reset_n, .system_reset_n, .irq);
`default_nettype wire
